// ===== pkg/sab_map.vh
// Register map, field positions, reset values and timing of the global control bank
`ifndef SAB_MAP_VH
`define SAB_MAP_VH

// Register indices; byte address is four times the index
`define SAB_IDX_GC3 6'h03
`define SAB_IDX_GC4 6'h04
`define SAB_IDX_STAT 6'h05

// Control three field positions
`define SAB_GC3_AGE_EN 2
`define SAB_GC3_FAST_AGE 1
`define SAB_GC3_BACKOFF 0

// Control four field positions
`define SAB_GC4_VLAN_DISC 7
`define SAB_GC4_MC_EXCL 6
`define SAB_GC4_BP_MODE 5
`define SAB_GC4_FAIR 4
`define SAB_GC4_COLL_KEEP 3

// Status field positions
`define SAB_ST_AGE_RUN 0
`define SAB_ST_FAST_RUN 1
`define SAB_ST_STRAP_AGE 2
`define SAB_ST_STRAP_BO 3
`define SAB_ST_STRAP_COLL 4
`define SAB_ST_STRAP_DONE 5

// Reset values; the three strap-backed ones are held until the straps are taken
`define SAB_RST_AGE_EN 1'b1
`define SAB_RST_FAST_AGE 1'b0
`define SAB_RST_BACKOFF 1'b0
`define SAB_RST_VLAN_DISC 1'b1
`define SAB_RST_MC_EXCL 1'b1
`define SAB_RST_BP_MODE 1'b1
`define SAB_RST_FAIR 1'b1
`define SAB_RST_COLL_KEEP 1'b0

// Excessive collision threshold
`define SAB_EXCESS_COLL 5'h10

// Timing: figures and clock rate
`define SAB_CLK_HZ 32'd10000000
`define SAB_CLK_MHZ 32'd10
`define SAB_NORMAL_AGE_S 32'd300
`define SAB_FAST_AGE_US 32'd800
`define SAB_NORMAL_AGE_CYC (`SAB_NORMAL_AGE_S * `SAB_CLK_HZ)
`define SAB_FAST_AGE_CYC (`SAB_FAST_AGE_US * `SAB_CLK_MHZ)

`endif

// ===== design/sab_strap_latch.v
// Strap capture for the aging, back-off and collision reset defaults
`timescale 1ns/1ps
`default_nettype none
`include "sab_map.vh"

module sab_strap_latch (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Strap pins
    input wire agingStrapPin,
    input wire backoffStrapPin,
    input wire collisionDropStrapPin,
    // Captured values
    output reg strapAge_q,
    output reg strapBackoff_q,
    output reg strapCollKeep_q,
    output reg strapLoad_q,
    output reg strapDone_q
);

    // Pins are sampled on the first edge after release, never under reset
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strapAge_q <= `SAB_RST_AGE_EN;
            strapBackoff_q <= `SAB_RST_BACKOFF;
            strapCollKeep_q <= `SAB_RST_COLL_KEEP;
            strapLoad_q <= 1'b0;
            strapDone_q <= 1'b0;
        end else begin
            strapLoad_q <= 1'b0;
            if (!strapDone_q) begin
                strapAge_q <= agingStrapPin;
                strapBackoff_q <= backoffStrapPin;
                strapCollKeep_q <= collisionDropStrapPin;
                strapLoad_q <= 1'b1; // One-cycle load into control bits
                strapDone_q <= 1'b1;
            end
        end
    end

endmodule // sab_strap_latch
`default_nettype wire

// ===== design/sab_age_timer.v
// Address table aging interval timer with normal and fast intervals
`timescale 1ns/1ps
`default_nettype none
`include "sab_map.vh"

module sab_age_timer #(
    parameter [31:0] NORMAL_CYC = `SAB_NORMAL_AGE_CYC,
    parameter [31:0] FAST_CYC = `SAB_FAST_AGE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Control
    input wire ageEnable,
    input wire fastAge,
    // Results
    output reg ageTick_q,
    output reg fastRun_q
);

    reg [31:0] count_q;
    wire [31:0] limit;

    assign limit = fastAge ? FAST_CYC : NORMAL_CYC;

    // A change of interval restarts the count so a stale long count
    // cannot delay the first fast sweep
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 32'h0000_0000;
            ageTick_q <= 1'b0;
            fastRun_q <= 1'b0;
        end else begin
            ageTick_q <= 1'b0;
            fastRun_q <= ageEnable & fastAge;
            if (!ageEnable) begin
                count_q <= 32'h0000_0000; // Aging stops entirely
            end else if (fastAge != fastRun_q) begin
                count_q <= 32'h0000_0000;
            end else if (count_q >= limit - 32'h0000_0001) begin
                count_q <= 32'h0000_0000;
                ageTick_q <= 1'b1; // One aging sweep per interval
            end else begin
                count_q <= count_q + 32'h0000_0001;
            end
        end
    end

endmodule // sab_age_timer
`default_nettype wire

// ===== design/sab_global_ctrl.v
// Global aging, back-off, storm scope and port-VLAN control bank on APB
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sab_map.vh"

// Function
// - Aging enable set ages learned entries; cleared stops aging completely.
// - Aging enable reset value follows its strap pin, default pulled up.
// - Fast age bit shortens aging interval to about 800 us; resets zero.
// - Aggressive back-off bit selects non-standard half-duplex back-off.
// - Aggressive back-off reset value follows its strap pin, pulled down.
// - Mismatch discard set blocks all VLAN crossing; cleared lets known unicast.
// - Storm exclusion set regulates broadcast only; cleared adds DA bit 40.
// - Back-pressure mode set is carrier-sense based, cleared collision based.
// - Fair mode set may drop non-flow-controlled port packets on contention.
// - Fair mode cleared flow-controls the flow-controlled port on contention.
// - Collision keep cleared drops frames at 16 collisions; set keeps them.
// - Collision keep reset value follows its strap pin, pulled down.
// - Normal aging interval is about 300 s; fast aging returns to it.
module sab_global_ctrl #(
    parameter [31:0] NORMAL_AGE_CYC = `SAB_NORMAL_AGE_CYC,
    parameter [31:0] FAST_AGE_CYC = `SAB_FAST_AGE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Strap pins
    input wire agingStrapPin,
    input wire backoffStrapPin,
    input wire collisionDropStrapPin,
    // Frame attributes from the forwarding logic
    input wire frmDaAllOnes,
    input wire frmDaBit40,
    input wire frmVlanCross,
    input wire frmKnownUnicast,
    input wire [4:0] frmCollCount,
    input wire egressContend,
    // Control levels to the datapath
    output reg ageEnable_q,
    output reg fastAge_q,
    output reg aggrBackoff_q,
    output reg bpCarrierSense_q,
    output reg fairMode_q,
    // Aging sweep request
    output wire ageTick_q,
    // Per-frame decisions
    output reg stormRegulate_q,
    output reg vlanBlock_q,
    output reg collisionDrop_q,
    output reg dropNonFc_q,
    output reg holdFcPort_q
);

    // Bits that only steer decisions inside this block
    reg vlanDiscard_q;
    reg mcExclude_q;
    reg collKeep_q;

    // Strap capture results and the age timer's fast-run status
    wire strapAge;
    wire strapBackoff;
    wire strapCollKeep;
    wire strapLoad;
    wire strapDone;
    wire fastRun;

    // Bus decode
    wire [5:0] regIdx;
    wire accessPhase;
    wire doWrite;
    wire hitGc3;
    wire hitGc4;
    wire hitStat;
    wire mapped;
    reg [7:0] readMux;

    assign regIdx = paddr[7:2];
    assign accessPhase = psel & penable;
    assign hitGc3 = (regIdx == `SAB_IDX_GC3);
    assign hitGc4 = (regIdx == `SAB_IDX_GC4);
    assign hitStat = (regIdx == `SAB_IDX_STAT);
    assign mapped = hitGc3 | hitGc4 | hitStat;
    // Write lands only at the edge where the master sees pready
    assign doWrite = accessPhase & pready & pwrite;

    // Strap pins taken once after reset release
    sab_strap_latch u_strap (
        .mclk(mclk),
        .reset_n(reset_n),
        .agingStrapPin(agingStrapPin),
        .backoffStrapPin(backoffStrapPin),
        .collisionDropStrapPin(collisionDropStrapPin),
        .strapAge_q(strapAge),
        .strapBackoff_q(strapBackoff),
        .strapCollKeep_q(strapCollKeep),
        .strapLoad_q(strapLoad),
        .strapDone_q(strapDone)
    );

    // Aging interval generator
    sab_age_timer #(
        .NORMAL_CYC(NORMAL_AGE_CYC),
        .FAST_CYC(FAST_AGE_CYC)
    ) u_age (
        .mclk(mclk),
        .reset_n(reset_n),
        .ageEnable(ageEnable_q),
        .fastAge(fastAge_q),
        .ageTick_q(ageTick_q),
        .fastRun_q(fastRun)
    );

    // Read data, unused bits read as zero
    always @* begin
        readMux = 8'h00;
        if (hitGc3) begin
            readMux[`SAB_GC3_AGE_EN] = ageEnable_q;
            readMux[`SAB_GC3_FAST_AGE] = fastAge_q;
            readMux[`SAB_GC3_BACKOFF] = aggrBackoff_q;
        end else if (hitGc4) begin
            readMux[`SAB_GC4_VLAN_DISC] = vlanDiscard_q;
            readMux[`SAB_GC4_MC_EXCL] = mcExclude_q;
            readMux[`SAB_GC4_BP_MODE] = bpCarrierSense_q;
            readMux[`SAB_GC4_FAIR] = fairMode_q;
            readMux[`SAB_GC4_COLL_KEEP] = collKeep_q;
        end else if (hitStat) begin
            readMux[`SAB_ST_AGE_RUN] = ageEnable_q;
            readMux[`SAB_ST_FAST_RUN] = fastRun;
            readMux[`SAB_ST_STRAP_AGE] = strapAge;
            readMux[`SAB_ST_STRAP_BO] = strapBackoff;
            readMux[`SAB_ST_STRAP_COLL] = strapCollKeep;
            readMux[`SAB_ST_STRAP_DONE] = strapDone;
        end
    end

    // APB answer: one wait state, so pready and data come from flops
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            if (accessPhase & !pready) begin
                pready <= 1'b1;
                pslverr <= !mapped; // Unmapped address answers with error
                prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, readMux};
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Control three: host writes win over the strap load, which can only
    // happen on the second edge after release before any access completes
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ageEnable_q <= `SAB_RST_AGE_EN;
            fastAge_q <= `SAB_RST_FAST_AGE;
            aggrBackoff_q <= `SAB_RST_BACKOFF;
        end else if (doWrite & hitGc3) begin
            ageEnable_q <= pwdata[`SAB_GC3_AGE_EN];
            fastAge_q <= pwdata[`SAB_GC3_FAST_AGE];
            aggrBackoff_q <= pwdata[`SAB_GC3_BACKOFF];
        end else if (strapLoad) begin
            ageEnable_q <= strapAge;
            aggrBackoff_q <= strapBackoff;
        end
    end

    // Control four: fixed defaults, only the keep bit follows a strap
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            vlanDiscard_q <= `SAB_RST_VLAN_DISC;
            mcExclude_q <= `SAB_RST_MC_EXCL;
            bpCarrierSense_q <= `SAB_RST_BP_MODE;
            fairMode_q <= `SAB_RST_FAIR;
            collKeep_q <= `SAB_RST_COLL_KEEP;
        end else if (doWrite & hitGc4) begin
            vlanDiscard_q <= pwdata[`SAB_GC4_VLAN_DISC];
            mcExclude_q <= pwdata[`SAB_GC4_MC_EXCL];
            bpCarrierSense_q <= pwdata[`SAB_GC4_BP_MODE];
            fairMode_q <= pwdata[`SAB_GC4_FAIR];
            collKeep_q <= pwdata[`SAB_GC4_COLL_KEEP];
        end else if (strapLoad) begin
            collKeep_q <= strapCollKeep;
        end
    end

    // Per-frame decisions track the current bits every cycle, so a new
    // setting acts on the next frame with no further trigger
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stormRegulate_q <= 1'b0;
            vlanBlock_q <= 1'b0;
            collisionDrop_q <= 1'b0;
            dropNonFc_q <= 1'b0;
            holdFcPort_q <= 1'b0;
        end else begin
            // Multicast joins the storm class only when not excluded
            stormRegulate_q <= frmDaAllOnes | (!mcExclude_q & frmDaBit40);
            // Only known unicast may cross, and only with discard off
            vlanBlock_q <= frmVlanCross & (vlanDiscard_q | !frmKnownUnicast);
            // Drop at the excessive collision limit unless kept
            collisionDrop_q <= !collKeep_q &
                (frmCollCount >= `SAB_EXCESS_COLL);
            // Fair mode sacrifices the non-flow-controlled source
            dropNonFc_q <= egressContend & fairMode_q;
            // Unfair mode holds off the flow-controlled source
            holdFcPort_q <= egressContend & !fairMode_q;
        end
    end

endmodule // sab_global_ctrl
`default_nettype wire

// ===== dv/sab_global_ctrl_props.sv
// Port assertions for the global control bank
`timescale 1ns/1ps
`default_nettype none
module sab_global_ctrl_props (
    // Clock, reset and bus handshake
    input wire mclk, reset_n, psel, penable, pready,
    // Frame attributes
    input wire frmDaAllOnes, frmDaBit40, frmVlanCross, frmKnownUnicast,
    input wire [4:0] frmCollCount,
    input wire egressContend,
    // Controls and decisions
    input wire ageEnable_q, fairMode_q, ageTick_q, stormRegulate_q,
    input wire vlanBlock_q, collisionDrop_q, dropNonFc_q, holdFcPort_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Exactly one wait state, then a single-cycle answer
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    apb_ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stuck");
    storm_bcast_a: assert property (frmDaAllOnes |=> stormRegulate_q)
        else $error("broadcast not regulated");
    storm_plain_a: assert property (!frmDaAllOnes && !frmDaBit40 |=> !stormRegulate_q)
        else $error("plain frame regulated");
    vlan_unknown_a: assert property (frmVlanCross && !frmKnownUnicast |=> vlanBlock_q)
        else $error("unknown crossing passed");
    coll_low_a: assert property (frmCollCount < 5'h10 |=> !collisionDrop_q)
        else $error("early collision drop");
    // Contention outcome follows the fair bit of the previous cycle
    fair_split_a: assert property (##1 1 |-> dropNonFc_q == ($past(egressContend) && $past(fairMode_q))
        && holdFcPort_q == ($past(egressContend) && !$past(fairMode_q)))
        else $error("contention outcome wrong");
    age_off_a: assert property (!ageEnable_q [*2] |-> !ageTick_q)
        else $error("tick while aging off");
    age_pulse_a: assert property (ageTick_q |=> !ageTick_q)
        else $error("tick longer than a cycle");
    cover property (ageTick_q);
    cover property (vlanBlock_q);
    cover property (holdFcPort_q);
endmodule // sab_global_ctrl_props
`default_nettype wire

// ===== dv/sab_apb_host.sv
// Host model: APB master reaching the control bank
`timescale 1ns/1ps
`default_nettype none
module sab_apb_host (
    // Clock
    input wire logic mclk,
    // APB request
    output logic psel, penable, pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready, pslverr
);
    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0;
    end
    // One transfer, held until pready is seen; an idle cycle follows.
    // pready is looked at mid-cycle, where it is settled, so the edge
    // that launches it never races the check; the bench watchdog
    // ends a wait that never gets an answer
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(negedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        @(posedge mclk);
        psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
        @(posedge mclk);
    endtask
endmodule // sab_apb_host
`default_nettype wire

// ===== dv/switch_aging_backoff_global_control_bench.sv
// Self-checking bench for the global control bank
`timescale 1ns/1ps
`default_nettype none
module switch_aging_backoff_global_control_bench;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0] strap;
    logic [9:0] frm;
    logic [4:0] dec;
    logic ageEn, fast, aggr, bpCs, fair, tick, rerr;
    int error_cnt = 0, compares = 0, n, i;
    logic [22:0] tab [0:10] = '{{8'h08,10'h100,5'h10}, {8'h08,10'h0C0,5'h00},
        {8'h08,10'h080,5'h08}, {8'h08,10'h020,5'h00}, {8'h08,10'h001,5'h01},
        {8'hF0,10'h100,5'h00}, {8'hF0,10'h200,5'h10}, {8'hF0,10'h0C0,5'h08},
        {8'hF0,10'h020,5'h04}, {8'hF0,10'h01E,5'h00}, {8'hF0,10'h001,5'h02}};
    // Clock at 10 MHz
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    sab_apb_host host (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    sab_global_ctrl #(.NORMAL_AGE_CYC(32'd40), .FAST_AGE_CYC(32'd10)) dut (
        .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .agingStrapPin(strap[2]),
        .backoffStrapPin(strap[1]), .collisionDropStrapPin(strap[0]),
        .frmDaAllOnes(frm[9]), .frmDaBit40(frm[8]), .frmVlanCross(frm[7]),
        .frmKnownUnicast(frm[6]), .frmCollCount(frm[5:1]),
        .egressContend(frm[0]), .ageEnable_q(ageEn), .fastAge_q(fast),
        .aggrBackoff_q(aggr), .bpCarrierSense_q(bpCs), .fairMode_q(fair),
        .ageTick_q(tick), .stormRegulate_q(dec[4]), .vlanBlock_q(dec[3]),
        .collisionDrop_q(dec[2]), .dropNonFc_q(dec[1]), .holdFcPort_q(dec[0]));
    task chk(input string nm, input logic [8:0] e, input logic [8:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task rst(input logic [2:0] s);
        strap <= s; reset_n <= 1'b0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, rdat, rerr);
    endtask
    task rd(input logic [7:0] a, input logic [8:0] e, input string nm);
        host.xfer(1'b0, a, 32'h0, rdat, rerr);
        chk(nm, e, {rerr, rdat[7:0]});
    endtask
    // Period between two sweep ticks, bounded
    task period(output int p);
        n = 0;
        while (tick !== 1'b1 && n < 200) begin @(posedge mclk); #1 n++; end
        p = 0;
        do begin @(posedge mclk); #1 p++; end while (tick !== 1'b1 && p < 200);
        @(posedge mclk);
    endtask
    task conclude;
        $display("Comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        conclude;
    end
    initial begin
        reset_n = 1'b0; strap = 3'b100; frm = 10'h0;
        rst(3'b100);
        rd(8'h0C, 9'h004, "ctl3");
        rd(8'h10, 9'h0F0, "ctl4");
        rd(8'h3C, 9'h100, "unmapped");
        $display("test reset defaults done");
        rst(3'b011);
        rd(8'h0C, 9'h001, "ctl3 strap");
        rd(8'h10, 9'h0F8, "ctl4 strap");
        rd(8'h14, 9'h038, "status strap");
        chk("age level", 9'h000, {8'h0, ageEn});
        $display("test strap defaults done");
        for (i = 0; i < 11; i++) begin
            wr(8'h10, tab[i][22:15]);
            frm <= tab[i][14:5];
            repeat (2) @(posedge mclk);
            #1 chk("decision", {4'h0, tab[i][4:0]}, {4'h0, dec});
        end
        frm <= 10'h0;
        wr(8'h10, 8'h08);
        rd(8'h10, 9'h008, "ctl4 rw");
        chk("bp fair", 9'h0, {7'h0, bpCs, fair});
        $display("test datapath done");
        rst(3'b100);
        period(n);
        chk("normal age", 9'd40, n[8:0]);
        wr(8'h0C, 8'h06);
        chk("fast bit", 9'h001, {8'h0, fast});
        period(n);
        chk("fast age", 9'd10, n[8:0]);
        wr(8'h0C, 8'h05);
        period(n);
        chk("age back", 9'd40, n[8:0]);
        chk("backoff", 9'h001, {8'h0, aggr});
        wr(8'h0C, 8'h00);
        period(n);
        chk("age off", 9'd200, n[8:0]);
        $display("test aging done");
        conclude;
    end
endmodule // switch_aging_backoff_global_control_bench
bind sab_global_ctrl sab_global_ctrl_props chk (.mclk(mclk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
    .frmDaAllOnes(frmDaAllOnes), .frmDaBit40(frmDaBit40),
    .frmVlanCross(frmVlanCross), .frmKnownUnicast(frmKnownUnicast),
    .frmCollCount(frmCollCount), .egressContend(egressContend),
    .ageEnable_q(ageEnable_q), .fairMode_q(fairMode_q),
    .ageTick_q(ageTick_q), .stormRegulate_q(stormRegulate_q),
    .vlanBlock_q(vlanBlock_q), .collisionDrop_q(collisionDrop_q),
    .dropNonFc_q(dropNonFc_q), .holdFcPort_q(holdFcPort_q));
`default_nettype wire
